// ---- rtl/vectored_interrupt_arbiter.sv ----
// Vector dispatch: arbitration, PC low byte replace and vector fetch
`timescale 1ns/1ns
`include "via_params.svh"
module vectored_interrupt_arbiter
  import via_pkg::*;
(
  input  wire logic        core_clk,     // Instruction clock
  input  wire logic        srst,         // Synchronous reset, high
  input  wire logic        dispatch,     // First cycle of dispatch instruction
  input  wire logic [14:0] dispatch_pc,  // Address of the dispatch instruction
  input  wire logic        trap_active,  // Software trap pending
  input  wire logic [11:0] irq_pending,  // Maskable pending, rank order
  input  wire logic [11:0] irq_enable,   // Maskable enables, rank order
  input  wire logic        mem_ready,    // Program memory byte valid
  input  wire logic [7:0]  mem_rdata,    // Program memory byte
  output logic             mem_req,      // Program memory read strobe
  output logic [14:0]      mem_addr,     // Program memory address
  output logic [7:0]       vec_code,     // Chosen low byte code
  output logic             pc_load,      // One-cycle PC load pulse
  output logic [14:0]      pc_value,     // New PC value
  output logic             busy          // Dispatch in progress
);
  // All module state
  typedef struct packed {
    via_state_t  st;
    logic        mem_req;
    logic [14:0] mem_addr;
    logic [7:0]  code;
    logic [6:0]  vec_hi;
    logic        pc_load;
    logic [14:0] pc_value;
    logic        busy;
  } via_regs_t;

  via_regs_t     r;       // Current state
  via_regs_t     next_r;  // Next state
  via_prio_if    pif ();  // Link to encoder
  logic [6:0]    page;    // Table page number

  // Maskable sources gate enable with pending
  assign pif.active = {irq_pending & irq_enable, trap_active};

  // Encoder instance
  via_prio_enc u_enc (
    .p (pif)
  );

  // Page holding the table, next page when dispatch sits on last byte
  always_comb begin
    if (dispatch_pc[7:0] == `VIA_BLOCK_LAST) begin
      page = 7'(dispatch_pc[14:8] + `VIA_BLOCK_INC);
    end else begin
      page = dispatch_pc[14:8];
    end
  end

  // Next state logic
  always_comb begin
    next_r         = r;
    next_r.pc_load = 1'b0;
    unique case (r.st)
      VIA_IDLE: begin
        if (dispatch) begin
          // Code latched once, later changes ignored
          next_r.code     = pif.code;
          next_r.mem_addr = {page, pif.code};
          next_r.mem_req  = 1'b1;
          next_r.busy     = 1'b1;
          next_r.st       = VIA_FETCH_HI;
        end
      end
      VIA_FETCH_HI: begin
        if (mem_ready) begin
          next_r.vec_hi   = mem_rdata[6:0];
          next_r.mem_addr = 15'(r.mem_addr + `VIA_ADDR_INC);
          next_r.st       = VIA_FETCH_LO;
        end
      end
      VIA_FETCH_LO: begin
        if (mem_ready) begin
          next_r.mem_req  = 1'b0;
          next_r.pc_value = {r.vec_hi, mem_rdata};
          next_r.pc_load  = 1'b1;
          next_r.st       = VIA_LOAD;
        end
      end
      VIA_LOAD: begin
        next_r.busy = 1'b0;
        next_r.st   = VIA_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      r <= '{st: VIA_IDLE, mem_req: 1'b0, mem_addr: `VIA_ZERO_PC,
             code: `VIA_CODE_BASE, vec_hi: `VIA_ZERO_HI, pc_load: 1'b0,
             pc_value: `VIA_ZERO_PC, busy: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flops
  assign mem_req  = r.mem_req;
  assign mem_addr = r.mem_addr;
  assign vec_code = r.code;
  assign pc_load  = r.pc_load;
  assign pc_value = r.pc_value;
  assign busy     = r.busy;

  // Trap forces code FE at dispatch
  a_trap_code: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_IDLE && dispatch && trap_active) |=> vec_code == `VIA_CODE_TOP)
    else $error("trap did not give FE");

  // External pin gives FA without trap
  a_ext_code: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_IDLE && dispatch && !trap_active && irq_pending[0] && irq_enable[0])
    |=> vec_code == `VIA_CODE_EXT)
    else $error("external pin did not give FA");

  // Nothing active gives E0
  a_default_code: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_IDLE && dispatch && !trap_active && (irq_pending & irq_enable) == 12'h000)
    |=> vec_code == `VIA_CODE_BASE)
    else $error("default code not E0");

  // Code is even and in range
  a_code_even: assert property (
    @(posedge core_clk) disable iff (srst)
    busy |-> (vec_code[0] == 1'b0 && vec_code >= `VIA_CODE_BASE))
    else $error("code odd or out of range");

  // Reserved slots never chosen
  a_no_reserved: assert property (
    @(posedge core_clk) disable iff (srst)
    busy |-> (vec_code != `VIA_CODE_RSV_HI && vec_code != `VIA_CODE_RSV_LO))
    else $error("reserved slot chosen");

  // Code holds through dispatch
  a_code_stable: assert property (
    @(posedge core_clk) disable iff (srst)
    (busy && $past(busy)) |-> $stable(vec_code))
    else $error("code changed during dispatch");

  // First fetch addresses the code in the table page
  a_fetch_addr: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_IDLE && dispatch) |=> (mem_req && mem_addr[7:0] == vec_code))
    else $error("fetch address low byte wrong");

  // Last-byte dispatch uses next page
  a_next_page: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_IDLE && dispatch && dispatch_pc[7:0] == `VIA_BLOCK_LAST)
    |=> mem_addr[14:8] == 7'($past(dispatch_pc[14:8]) + `VIA_BLOCK_INC))
    else $error("table page wrong");

  // Low byte follows high byte address
  a_lo_after_hi: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_FETCH_HI && mem_ready)
    |=> mem_addr == 15'($past(mem_addr) + `VIA_ADDR_INC))
    else $error("second byte address wrong");

  // PC load carries the second fetched byte in its low bits
  a_pc_load: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_FETCH_LO && mem_ready)
    |=> (pc_load && pc_value[7:0] == $past(mem_rdata)))
    else $error("vector not loaded");

  // Idle timer highest active gives F8
  a_timer0_code: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_IDLE && dispatch && !(|pif.active[1:0]) && pif.active[2])
    |=> vec_code == `VIA_CODE_IDLE_TMR)
    else $error("idle timer did not give F8");

  // Timer one A highest active gives F6
  a_timer1a_code: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_IDLE && dispatch && !(|pif.active[2:0]) && pif.active[3])
    |=> vec_code == `VIA_CODE_TMR1A)
    else $error("timer one A did not give F6");

  // Serial busy-falling highest active gives F2
  a_serial_code: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_IDLE && dispatch && !(|pif.active[4:0]) && pif.active[5])
    |=> vec_code == `VIA_CODE_SERIAL)
    else $error("serial did not give F2");

  // UART receive highest active gives EE
  a_uart_rx_code: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_IDLE && dispatch && !(|pif.active[5:0]) && pif.active[6])
    |=> vec_code == `VIA_CODE_UART_RX)
    else $error("uart receive did not give EE");

  // Timer three B highest active gives E4
  a_timer3b_code: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_IDLE && dispatch && !(|pif.active[10:0]) && pif.active[11])
    |=> vec_code == `VIA_CODE_TMR3B)
    else $error("timer three B did not give E4");

  // Port L edge alone gives E2
  a_port_l_code: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_IDLE && dispatch && !(|pif.active[11:0]) && pif.active[12])
    |=> vec_code == `VIA_CODE_PORT_L)
    else $error("port L did not give E2");

  // Enable bits gate pending bits
  a_mask_gate: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_IDLE && dispatch && !trap_active && irq_enable == 12'h000)
    |=> vec_code == `VIA_CODE_BASE)
    else $error("disabled source was chosen");

  // Code holds while no dispatch arrives
  a_code_hold_idle: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_IDLE && !dispatch) |=> $stable(vec_code))
    else $error("code changed without dispatch");

  // Dispatch while busy is refused
  a_busy_refuse: assert property (
    @(posedge core_clk) disable iff (srst)
    (busy && dispatch) |=> $stable(vec_code))
    else $error("dispatch taken while busy");

  // Sequencer frees itself for the next arbitration
  a_rearb_ready: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_LOAD) |=> (!busy && r.st == VIA_IDLE))
    else $error("not ready for next dispatch");

  // PC load lasts one cycle
  a_load_pulse: assert property (
    @(posedge core_clk) disable iff (srst)
    pc_load |=> !pc_load)
    else $error("pc load longer than one cycle");

  // PC upper bits come from the first byte
  a_pc_high: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_FETCH_LO && mem_ready)
    |=> pc_value[14:8] == $past(r.vec_hi))
    else $error("pc upper bits wrong");

  // First byte captured, top bit dropped
  a_hi_capture: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_FETCH_HI && mem_ready)
    |=> r.vec_hi == $past(mem_rdata[6:0]))
    else $error("high byte not captured");

  // Address and request hold through wait states
  a_addr_hold: assert property (
    @(posedge core_clk) disable iff (srst)
    ((r.st == VIA_FETCH_HI || r.st == VIA_FETCH_LO) && !mem_ready)
    |=> ($stable(mem_addr) && mem_req))
    else $error("fetch request moved during wait");

  // Request ends with the load pulse
  a_req_drop: assert property (
    @(posedge core_clk) disable iff (srst)
    pc_load |-> !mem_req)
    else $error("request still high at load");

  // Ordinary dispatch keeps its own page
  a_same_page: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_IDLE && dispatch && dispatch_pc[7:0] != `VIA_BLOCK_LAST)
    |=> mem_addr[14:8] == $past(dispatch_pc[14:8]))
    else $error("table page not the dispatch page");

  // Accepted dispatch raises busy
  a_busy_span: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_IDLE && dispatch) |=> busy)
    else $error("busy not raised on dispatch");

  // Idle sequencer holds request, load pulse and busy low
  a_idle_quiet: assert property (
    @(posedge core_clk) disable iff (srst)
    (r.st == VIA_IDLE) |-> (!mem_req && !pc_load && !busy))
    else $error("outputs active while idle");
endmodule

// ---- rtl/via_params.svh ----
// Constants for the vectored interrupt arbiter
`ifndef VIA_PARAMS_SVH
`define VIA_PARAMS_SVH
`define VIA_CODE_BASE   8'hE0
`define VIA_CODE_TOP    8'hFE
`define VIA_CODE_STEP   8'h02
`define VIA_NUM_RANKS   16
`define VIA_NUM_SRC     13
`define VIA_PC_W        15
`define VIA_BLOCK_LAST  8'hFF
`define VIA_BLOCK_INC   7'h01
`define VIA_ZERO_BYTE   8'h00
`define VIA_ZERO_PC     15'h0000
`define VIA_ZERO_SRC    13'h0000
`define VIA_ZERO_HI     7'h00
`define VIA_ADDR_INC    15'h0001
`define VIA_CODE_EXT    8'hFA
`define VIA_CODE_IDLE_TMR 8'hF8
`define VIA_CODE_TMR1A  8'hF6
`define VIA_CODE_SERIAL 8'hF2
`define VIA_CODE_UART_RX 8'hEE
`define VIA_CODE_TMR3B  8'hE4
`define VIA_CODE_PORT_L 8'hE2
`define VIA_CODE_RSV_HI 8'hFC
`define VIA_CODE_RSV_LO 8'hF0
`endif

// ---- rtl/via_pkg.sv ----
// Types for the vectored interrupt arbiter
package via_pkg;
  typedef enum logic [1:0] {
    VIA_IDLE,
    VIA_FETCH_HI,
    VIA_FETCH_LO,
    VIA_LOAD
  } via_state_t;
endpackage

// ---- rtl/via_prio_enc.sv ----
// Fixed-priority encoder producing the vector low byte
`timescale 1ns/1ns
`include "via_params.svh"
module via_prio_enc
  import via_pkg::*;
(
  via_prio_if.enc p
);
  // Rank of each source bit, 1 = highest; reserved ranks 2 and 8 unused
  function automatic logic [7:0] via_rank_code(input int unsigned idx);
    int unsigned rank;
    rank = (idx == 0) ? 1 : (idx < 6) ? idx + 2 : idx + 3;
    via_rank_code = 8'(`VIA_CODE_TOP - 8'(`VIA_CODE_STEP * (rank - 1)));
  endfunction

  // Scan from lowest to highest so the highest active wins
  always_comb begin
    p.code = `VIA_CODE_BASE;
    for (int i = `VIA_NUM_SRC - 1; i >= 0; i--) begin
      if (p.active[i]) begin
        p.code = via_rank_code(i);
      end
    end
  end
endmodule

// ---- rtl/via_prio_if.sv ----
// Request and code bundle between dispatch sequencer and priority encoder
`timescale 1ns/1ns
interface via_prio_if;
  logic [12:0] active;  // Enabled-and-pending sources, bit 0 = trap
  logic [7:0]  code;    // Even low byte E0..FE
  modport enc (input active, output code);
  modport seq (output active, input code);
endinterface

// ---- tb/vectored_interrupt_arbiter_tb.sv ----
// Self-checking bench for the vectored interrupt arbiter
`timescale 1ns/1ns
module vectored_interrupt_arbiter_tb;
  logic        core_clk = 0, srst = 1, dispatch = 0, trap_active = 0, slow = 0;
  logic [14:0] dispatch_pc = 15'h0000;
  logic [11:0] irq_pending = 12'h000, irq_enable = 12'h000;
  logic        mem_ready, mem_req, pc_load, busy;
  logic [7:0]  mem_rdata, vec_code;
  logic [14:0] mem_addr, pc_value;
  int          fails = 0, comparisons = 0, cycles = 0;
  always #5 core_clk = ~core_clk;
  vectored_interrupt_arbiter DUT (.core_clk(core_clk), .srst(srst), .dispatch(dispatch),
    .dispatch_pc(dispatch_pc), .trap_active(trap_active), .irq_pending(irq_pending),
    .irq_enable(irq_enable), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
    .mem_req(mem_req), .mem_addr(mem_addr), .vec_code(vec_code), .pc_load(pc_load),
    .pc_value(pc_value), .busy(busy));
  via_mem_model mem (.core_clk(core_clk), .mem_req(mem_req), .mem_addr(mem_addr),
    .slow(slow), .mem_ready(mem_ready), .mem_rdata(mem_rdata));
  // Compare and count
  task automatic check(input string what, input logic [14:0] seen, input logic [14:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      print_verdict();
    end
  end
  // One dispatch, then late input changes and a refused second request
  task automatic run(input logic [14:0] pc, input logic t, input logic [11:0] p,
                     input logic [11:0] e, input logic [7:0] exp);
    logic [14:0] tbl;
    logic [7:0]  hi;
    int          n;
    tbl = {pc[14:8] + ((pc[7:0] == 8'hFF) ? 7'h01 : 7'h00), exp};
    hi = tbl[7:0] ^ 8'h5A;
    @(posedge core_clk);
    dispatch <= 1;
    dispatch_pc <= pc;
    trap_active <= t;
    irq_pending <= p;
    irq_enable <= e;
    @(posedge core_clk);
    trap_active <= ~t;
    irq_pending <= ~p;
    irq_enable <= 12'hFFF;
    dispatch_pc <= ~pc;
    @(negedge core_clk);
    check("table address", mem_addr, tbl);
    check("request", {14'h0, mem_req}, 15'h1);
    check("busy", {14'h0, busy}, 15'h1);
    @(posedge core_clk);
    dispatch <= 0;
    n = 0;
    while (pc_load !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    check("code", {7'h0, vec_code}, {7'h0, exp});
    check("new pc", pc_value, {hi[6:0], (tbl[7:0] + 8'h01) ^ 8'h5A});
    check("request drop", {14'h0, mem_req}, 15'h0);
    @(negedge core_clk);
    check("load pulse", {14'h0, pc_load}, 15'h0);
    check("idle", {14'h0, busy}, 15'h0);
  endtask
  // Reset in the middle of a dispatch returns the outputs to idle
  task automatic reset_mid;
    @(posedge core_clk);
    dispatch <= 1;
    trap_active <= 1;
    @(posedge core_clk);
    dispatch <= 0;
    srst <= 1;
    @(posedge core_clk);
    @(negedge core_clk);
    check("reset mid code", {7'h0, vec_code}, 15'h00E0);
    check("reset mid busy", {14'h0, busy}, 15'h0);
    check("reset mid pc", pc_value, 15'h0000);
    @(posedge core_clk);
    srst <= 0;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 0;
    @(negedge core_clk);
    check("reset code", {7'h0, vec_code}, 15'h00E0);
    run(15'h0100, 1, 12'hFFF, 12'hFFF, 8'hFE);
    run(15'h0234, 1, 12'h000, 12'h000, 8'hFE);
    for (int i = 0; i < 12; i++) begin
      run(15'h0300 + 15'(i), 0, 12'h001 << i, 12'hFFF,
          (i < 5) ? 8'hFA - 8'(2 * i) : 8'hEE - 8'(2 * (i - 5)));
    end
    run(15'h0400, 0, 12'hFFF, 12'h000, 8'hE0);
    run(15'h0410, 0, 12'h800, 12'h7FF, 8'hE0);
    run(15'h0500, 0, 12'hFFF, 12'hFFF, 8'hFA);
    run(15'h0500, 0, 12'hFFE, 12'hFFF, 8'hF8);
    run(15'h0600, 0, 12'hFE0, 12'hFFF, 8'hEE);
    reset_mid();
    slow = 1;
    run(15'h00FF, 0, 12'h010, 12'hFFF, 8'hF2);
    run(15'h7FFF, 1, 12'h000, 12'h000, 8'hFE);
    slow = 0;
    print_verdict();
  end
endmodule

// ---- tb/via_mem_model.sv ----
// Program memory model answering vector byte reads
`timescale 1ns/1ns
module via_mem_model (
  input  wire logic        core_clk,
  input  wire logic        mem_req,
  input  wire logic [14:0] mem_addr,
  input  wire logic        slow,
  output logic             mem_ready,
  output logic [7:0]       mem_rdata
);
  logic       stall = 1'b0;   // Wait state toggle when slow
  logic [7:0] last  = 8'h00;  // Last byte handed out
  // Insert one wait cycle before each byte when slow
  always_ff @(posedge core_clk) begin
    stall <= mem_req & slow & ~stall;
    if (mem_ready) begin
      last <= mem_rdata;
    end
  end
  assign mem_ready = mem_req & (~slow | stall);
  // Byte is a scramble of the address; junk while not answering
  assign mem_rdata = mem_ready ? (mem_addr[7:0] ^ 8'h5A) : ~last;
endmodule
